/* File: rtl/sfs_fault_supervisor.v */
// second-stage fault supervisor: apb registers, blanking, fault fsm, restart, sensor rate
//
// Notes on behaviour
// - overcurrent blanked 150 ns plus 50 ns steps
// - open-loop blanked 1 us plus 0.5 us steps
// - fixed overvoltage blanking 1 us plus 0.5 us
// - type bit picks fixed or previous interval minus 500ns
// - temperature sampled fast or slow outside fault
// - overcurrent needs n consecutive events, 0 forces
// - open-loop needs n consecutive events, 0 forces
// - overvoltage needs n consecutive events, 0 forces
// - per-fault bit picks latched or unlatched
// - restart delay is setting times fast/slow tick
// - scope bit: second stage only or both
// - enable bits, zero turns protection on
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "sfs_map.vh"

module sfs_fault_supervisor #(
  // long counts, shortened in simulation
  parameter FAST_TICK_CYC = (`SFS_RESTART_FAST_NS * `SFS_CLK_MHZ) / 1000,
  parameter SLOW_TICK_CYC = `SFS_RESTART_SLOW_US * `SFS_CLK_MHZ,
  parameter TEMP_FAST_CYC = 25000,
  parameter TEMP_SLOW_CYC = 250000
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  // converter switching and sense comparators
  input wire sw_on_pulse,
  input wire sw_off_pulse,
  input wire overcurrent_cmp,
  input wire open_loop_cmp,
  input wire overvoltage_cmp,
  // temperature sensor
  input wire internal_overtemp_fault,
  output reg temp_sample_strobe,
  // stage shutdown
  output wire stage2_off,
  output wire boost_off
);

  ////////////////////////////////////////////////////////////////////////////
  // fault state machine codes

  localparam [2:0] ST_RUN = 3'b001; // stages running
  localparam [2:0] ST_WAIT = 3'b010; // unlatched fault, counting down
  localparam [2:0] ST_LATCH = 3'b100; // latched fault, held until reset

  ////////////////////////////////////////////////////////////////////////////
  // registers and state

  reg [7:0] enables_ff; // protection disable bits
  reg [7:0] blank_ff; // blanking settings and sensor rate
  reg [7:0] counts_ff; // count thresholds and latch types
  reg [7:0] ov_setup_ff; // overvoltage setup
  reg [7:0] restart_ff; // restart time, slow bit, scope
  reg [2:0] state_ff; // fault fsm
  reg [2:0] nxt_state;
  reg [2:0] cause_ff; // faults seen at last entry
  reg [2:0] nxt_cause;
  reg scope_ff; // shutdown scope held for this fault
  reg nxt_scope;
  reg [5:0] left_ff; // restart ticks remaining
  reg [5:0] nxt_left;
  reg [23:0] pre_ff; // restart tick prescaler
  reg [23:0] nxt_pre;
  reg [15:0] t2_cnt_ff; // running interval since turn-off
  reg [15:0] t2_prev_ff; // last completed interval
  reg t2_run_ff; // interval measurement running
  reg [23:0] temp_cnt_ff; // sensor sample divider

  ////////////////////////////////////////////////////////////////////////////
  // field views

  wire [3:0] oc_blank_set = blank_ff[`SFS_OC_BLANK_MSB:`SFS_OC_BLANK_LSB];
  wire [2:0] ol_blank_set = blank_ff[`SFS_OL_BLANK_MSB:`SFS_OL_BLANK_LSB];
  wire [2:0] ov_blank_set = ov_setup_ff[`SFS_OV_BLANK_MSB:`SFS_OV_BLANK_LSB];
  wire [2:0] oc_cnt_set = counts_ff[`SFS_OC_CNT_MSB:`SFS_OC_CNT_LSB];
  wire [2:0] ol_cnt_set = counts_ff[`SFS_OL_CNT_MSB:`SFS_OL_CNT_LSB];
  wire [2:0] ov_cnt_set = ov_setup_ff[`SFS_OV_CNT_MSB:`SFS_OV_CNT_LSB];
  wire [5:0] restart_set = restart_ff[`SFS_RESTART_MSB:`SFS_RESTART_LSB];
  wire running = state_ff[0];

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; every access completes with no wait state

  wire [11:0] a_en = {2'b00, `SFS_IDX_ENABLES, 2'b00};
  wire [11:0] a_blank = {2'b00, `SFS_IDX_BLANK, 2'b00};
  wire [11:0] a_counts = {2'b00, `SFS_IDX_COUNTS, 2'b00};
  wire [11:0] a_ov = {2'b00, `SFS_IDX_OV_SETUP, 2'b00};
  wire [11:0] a_restart = {2'b00, `SFS_IDX_RESTART, 2'b00};
  wire [11:0] a_status = {2'b00, `SFS_IDX_STATUS, 2'b00};
  wire setup_ph = psel & ~penable; // read data prepared here
  wire wr_acc = psel & penable & pwrite; // write lands at access edge
  reg [31:0] rd_mux; // read value of the addressed word
  reg hit_addr; // address maps to a register

  assign pready = 1'b1;

  // read mux; unmapped words read zero and error
  always @* begin
    rd_mux = 32'h0000_0000;
    hit_addr = 1'b1;
    case (paddr)
      a_en: rd_mux = {24'h000000, enables_ff};
      a_blank: rd_mux = {24'h000000, blank_ff};
      a_counts: rd_mux = {24'h000000, counts_ff};
      a_ov: rd_mux = {24'h000000, ov_setup_ff};
      a_restart: rd_mux = {24'h000000, restart_ff};
      a_status: rd_mux = {26'h0000000, cause_ff, state_ff};
      default: hit_addr = 1'b0;
    endcase
  end

  // read data and error registered in the setup phase
  always @(posedge core_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata <= rd_mux;
      pslverr <= ~hit_addr;
    end
  end

  // register writes; status is read-only
  always @(posedge core_clk) begin
    if (rst) begin
      enables_ff <= `SFS_RST_ENABLES;
      blank_ff <= `SFS_RST_BLANK;
      counts_ff <= `SFS_RST_COUNTS;
      ov_setup_ff <= `SFS_RST_OV_SETUP;
      restart_ff <= `SFS_RST_RESTART;
    end else if (wr_acc) begin
      // only the low byte is stored
      if (paddr == a_en) begin
        enables_ff <= pwdata[7:0];
      end
      if (paddr == a_blank) begin
        blank_ff <= pwdata[7:0];
      end
      if (paddr == a_counts) begin
        counts_ff <= pwdata[7:0];
      end
      if (paddr == a_ov) begin
        ov_setup_ff <= pwdata[7:0];
      end
      if (paddr == a_restart) begin
        restart_ff <= pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // blanking lengths in clock cycles, least times rounded up

  wire [31:0] oc_blank_w;
  wire [31:0] ol_blank_w;
  wire [31:0] ov_fix_w;
  wire [31:0] ov_less_w; // interval minus offset at full width
  wire [15:0] ov_t2_cyc; // interval minus offset, at least one
  wire [15:0] ov_blank_cyc;

  assign oc_blank_w = ((`SFS_OC_BASE_NS + `SFS_OC_STEP_NS * oc_blank_set)
    * `SFS_CLK_MHZ + 999) / 1000;
  assign ol_blank_w = ((`SFS_OL_BASE_NS + `SFS_OL_STEP_NS * ol_blank_set)
    * `SFS_CLK_MHZ + 999) / 1000;
  assign ov_fix_w = ((`SFS_OV_BASE_NS + `SFS_OV_STEP_NS * ov_blank_set)
    * `SFS_CLK_MHZ + 999) / 1000;
  // a too short interval still leaves one blanked cycle
  assign ov_less_w = t2_prev_ff - `SFS_T2_OFFSET_CYC;
  // only used when above the offset, so the low half holds the whole value
  assign ov_t2_cyc = (t2_prev_ff > `SFS_T2_OFFSET_CYC) ? ov_less_w[15:0] : 16'h0001;
  assign ov_blank_cyc = ov_setup_ff[`SFS_OV_TYPE_BIT] ? ov_t2_cyc
    : ov_fix_w[15:0];

  ////////////////////////////////////////////////////////////////////////////
  // previous switching interval: turn-off to next turn-on

  always @(posedge core_clk) begin
    if (rst) begin
      t2_cnt_ff <= 16'h0000;
      t2_prev_ff <= 16'h0000;
      t2_run_ff <= 1'b0;
    end else if (sw_off_pulse) begin
      t2_cnt_ff <= 16'h0001;
      t2_run_ff <= 1'b1;
    end else if (sw_on_pulse && t2_run_ff) begin
      // completed interval used for the next blanking
      t2_prev_ff <= t2_cnt_ff;
      t2_run_ff <= 1'b0;
    end else if (t2_run_ff && t2_cnt_ff != 16'hFFFF) begin
      // saturate rather than wrap on a stalled converter
      t2_cnt_ff <= t2_cnt_ff + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sense channels; disabled or faulted channels are held cleared

  wire oc_hit;
  wire ol_hit;
  wire ov_hit;
  wire oc_act = running & ~enables_ff[`SFS_EN_OC_BIT];
  wire ol_act = running & ~enables_ff[`SFS_EN_OL_BIT];
  wire ov_act = running & ~enables_ff[`SFS_EN_OV_BIT];

  // overcurrent, armed at switch turn-on
  sfs_event_counter u_oc (
    .core_clk(core_clk),
    .rst(rst),
    .arm_pulse(sw_on_pulse),
    .cmp_in(overcurrent_cmp),
    .active(oc_act),
    .blank_cycles(oc_blank_w[15:0]),
    .count_thr(oc_cnt_set),
    .fault_hit(oc_hit)
  );

  // open loop and sense resistor, armed at turn-on
  sfs_event_counter u_ol (
    .core_clk(core_clk),
    .rst(rst),
    .arm_pulse(sw_on_pulse),
    .cmp_in(open_loop_cmp),
    .active(ol_act),
    .blank_cycles(ol_blank_w[15:0]),
    .count_thr(ol_cnt_set),
    .fault_hit(ol_hit)
  );

  // output overvoltage, armed at switch turn-off
  sfs_event_counter u_ov (
    .core_clk(core_clk),
    .rst(rst),
    .arm_pulse(sw_off_pulse),
    .cmp_in(overvoltage_cmp),
    .active(ov_act),
    .blank_cycles(ov_blank_cyc),
    .count_thr(ov_cnt_set),
    .fault_hit(ov_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // fault fsm and restart countdown

  wire [2:0] hits = {ov_hit, ol_hit, oc_hit};
  wire latch_req = (oc_hit & counts_ff[`SFS_OC_LAT_BIT])
    | (ol_hit & counts_ff[`SFS_OL_LAT_BIT])
    | (ov_hit & ov_setup_ff[`SFS_OV_LAT_BIT]);
  // tick length follows the slow bit, read live
  wire [31:0] tick_last_w = restart_ff[`SFS_SLOW_BIT] ? SLOW_TICK_CYC - 1
    : FAST_TICK_CYC - 1;
  wire [23:0] tick_last = tick_last_w[23:0]; // longest tick fits in 24 bits

  // next state; any latched cause wins over unlatched ones
  always @* begin
    nxt_state = state_ff;
    nxt_cause = cause_ff;
    nxt_scope = scope_ff;
    nxt_left = left_ff;
    nxt_pre = pre_ff;
    case (state_ff)
      ST_RUN: begin
        if (hits != 3'b000) begin
          nxt_cause = hits;
          nxt_scope = restart_ff[`SFS_SCOPE_BIT];
          nxt_left = restart_set;
          nxt_pre = 24'h000000;
          nxt_state = latch_req ? ST_LATCH : ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (left_ff == 6'h00) begin
          nxt_state = ST_RUN;
        end else if (pre_ff >= tick_last) begin
          nxt_pre = 24'h000000;
          nxt_left = left_ff - 6'h01;
        end else begin
          nxt_pre = pre_ff + 24'h000001;
        end
      end
      ST_LATCH: begin
        // only reset leaves this state
        nxt_state = ST_LATCH;
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  // fsm registers
  always @(posedge core_clk) begin
    if (rst) begin
      state_ff <= ST_RUN;
      cause_ff <= 3'b000;
      scope_ff <= 1'b0;
      left_ff <= 6'h00;
      pre_ff <= 24'h000000;
    end else begin
      state_ff <= nxt_state;
      cause_ff <= nxt_cause;
      scope_ff <= nxt_scope;
      left_ff <= nxt_left;
      pre_ff <= nxt_pre;
    end
  end

  // stage shutdown from the fault state and held scope
  assign stage2_off = ~state_ff[0];
  assign boost_off = ~state_ff[0] & scope_ff;

  ////////////////////////////////////////////////////////////////////////////
  // internal temperature sampling rate

  // the overtemperature state always samples fast to catch recovery quickly
  wire slow_rate = blank_ff[`SFS_TEMP_RATE_BIT] & ~internal_overtemp_fault;
  wire [31:0] temp_last_w = slow_rate ? TEMP_SLOW_CYC - 1 : TEMP_FAST_CYC - 1;
  wire [23:0] temp_last = temp_last_w[23:0]; // slow period fits in 24 bits

  // divider producing a one-cycle sample strobe
  always @(posedge core_clk) begin
    if (rst) begin
      temp_cnt_ff <= 24'h000000;
      temp_sample_strobe <= 1'b0;
    end else if (temp_cnt_ff >= temp_last) begin
      temp_cnt_ff <= 24'h000000;
      temp_sample_strobe <= 1'b1;
    end else begin
      temp_cnt_ff <= temp_cnt_ff + 24'h000001;
      temp_sample_strobe <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* File: rtl/sfs_map.vh */
// register map, field positions, reset values and timing figures of the fault supervisor
`ifndef SFS_MAP_VH
`define SFS_MAP_VH

// register indices; byte address is four times the index
`define SFS_IDX_ENABLES 8'h4F
`define SFS_IDX_BLANK 8'h50
`define SFS_IDX_COUNTS 8'h51
`define SFS_IDX_OV_SETUP 8'h52
`define SFS_IDX_RESTART 8'h53
`define SFS_IDX_STATUS 8'h54

// reset values
`define SFS_RST_ENABLES 8'h00
`define SFS_RST_BLANK 8'h01
`define SFS_RST_COUNTS 8'h22
`define SFS_RST_OV_SETUP 8'h20
`define SFS_RST_RESTART 8'h04

// enable register, 0 = protection on
`define SFS_EN_OC_BIT 7
`define SFS_EN_OL_BIT 6
`define SFS_EN_OV_BIT 5

// blanking and sensor rate register
`define SFS_OC_BLANK_MSB 7
`define SFS_OC_BLANK_LSB 4
`define SFS_OL_BLANK_MSB 3
`define SFS_OL_BLANK_LSB 1
`define SFS_TEMP_RATE_BIT 0

// fault count register
`define SFS_OC_CNT_MSB 7
`define SFS_OC_CNT_LSB 5
`define SFS_OC_LAT_BIT 4
`define SFS_OL_CNT_MSB 3
`define SFS_OL_CNT_LSB 1
`define SFS_OL_LAT_BIT 0

// overvoltage register
`define SFS_OV_CNT_MSB 7
`define SFS_OV_CNT_LSB 5
`define SFS_OV_LAT_BIT 4
`define SFS_OV_TYPE_BIT 3
`define SFS_OV_BLANK_MSB 2
`define SFS_OV_BLANK_LSB 0

// restart register
`define SFS_RESTART_MSB 7
`define SFS_RESTART_LSB 2
`define SFS_SLOW_BIT 1
`define SFS_SCOPE_BIT 0

// timing figures
`define SFS_CLK_MHZ 250
`define SFS_OC_BASE_NS 150
`define SFS_OC_STEP_NS 50
`define SFS_OL_BASE_NS 1000
`define SFS_OL_STEP_NS 500
`define SFS_OV_BASE_NS 1000
`define SFS_OV_STEP_NS 500
`define SFS_T2_OFFSET_NS 500
`define SFS_RESTART_FAST_NS 25600
`define SFS_RESTART_SLOW_US 40960
`define SFS_T2_OFFSET_CYC ((`SFS_T2_OFFSET_NS * `SFS_CLK_MHZ) / 1000)

`endif

/* File: rtl/sfs_event_counter.v */
// one sense channel: blanking after arm, event capture and consecutive-event counting
`timescale 1ns/1ps
`default_nettype none

module sfs_event_counter (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // switching cycle and sense input
  input wire arm_pulse,
  input wire cmp_in,
  input wire active,
  // settings
  input wire [15:0] blank_cycles,
  input wire [2:0] count_thr,
  // fault decision
  output wire fault_hit
);

  reg [15:0] blank_ff; // cycles of blanking left
  reg seen_ff; // event seen in this cycle
  reg [2:0] cnt_ff; // consecutive events so far
  wire [3:0] cnt_sum; // count including the cycle now ending
  wire reach; // threshold met at this boundary

  assign cnt_sum = {1'b0, cnt_ff} + 4'h1;
  assign reach = arm_pulse & seen_ff & (cnt_sum >= {1'b0, count_thr});
  // setting 0 holds the fault on for debug
  assign fault_hit = active & ((count_thr == 3'h0) | reach);

  // blanking, capture and count; a quiet cycle breaks the run
  always @(posedge core_clk) begin
    if (rst || !active) begin
      blank_ff <= 16'h0000;
      seen_ff <= 1'b0;
      cnt_ff <= 3'h0;
    end else if (arm_pulse) begin
      blank_ff <= blank_cycles;
      seen_ff <= 1'b0;
      if (seen_ff && !reach) begin
        cnt_ff <= cnt_sum[2:0];
      end else begin
        cnt_ff <= 3'h0;
      end
    end else if (blank_ff != 16'h0000) begin
      // comparator ignored while blanked
      blank_ff <= blank_ff - 16'h0001;
    end else if (cmp_in) begin
      seen_ff <= 1'b1;
    end
  end

endmodule

`default_nettype wire

/* File: verif/sfs_checker_sva.sv */
// port-level assertions for the second-stage fault supervisor
`timescale 1ns/1ps
`default_nettype none

module sfs_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // apb slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // sensor strobe and stage shutdown
  input wire logic internal_overtemp_fault,
  input wire logic temp_sample_strobe,
  input wire logic stage2_off,
  input wire logic boost_off
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // access phase of a transfer
  wire logic acc = psel && penable;
  // wholly outside the register window; unaligned slots inside are left open
  wire logic outside = (paddr < 12'h13C) || (paddr > 12'h153);
  // aligned register slot
  wire logic slot = !outside && (paddr[1:0] == 2'h0);
  ////////////////////////////////////////////////////////////////////////////////
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_err_unmapped: assert property (acc && outside |-> pslverr)
    else $error("no error on unmapped address");
  chk_err_mapped: assert property (acc && slot |-> !pslverr)
    else $error("error on mapped register");
  chk_rd_unmapped: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_rd_upper: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_boost_scope: assert property (boost_off |-> stage2_off)
    else $error("boost off without second stage off");
  chk_reset_clear: assert property ($fell(rst) |-> !stage2_off && !boost_off && prdata == 32'h0)
    else $error("outputs not cleared by reset");
  chk_strobe_pulse: assert property (temp_sample_strobe |=> !temp_sample_strobe)
    else $error("sample strobe longer than one cycle");
  // fast rate is four cycles in this bench; an early strobe drops the attempt
  chk_strobe_fast: assert property (temp_sample_strobe && internal_overtemp_fault ##1
    (internal_overtemp_fault && !temp_sample_strobe)[*3] |=> temp_sample_strobe)
    else $error("fast sampling period wrong");
  ////////////////////////////////////////////////////////////////////////////////
  cov_fault: cover property ($rose(stage2_off));
  cov_both: cover property ($rose(boost_off));
  cov_err: cover property (acc && pslverr);
  cov_hot: cover property (temp_sample_strobe && internal_overtemp_fault);
endmodule

bind sfs_fault_supervisor sfs_checker sfs_checker_i (
  .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .internal_overtemp_fault(internal_overtemp_fault), .temp_sample_strobe(temp_sample_strobe),
  .stage2_off(stage2_off), .boost_off(boost_off));

`default_nettype wire

/* File: verif/sfs_conv_model.sv */
// converter model: switch on/off pulses and sense comparator levels
`timescale 1ns/1ps
`default_nettype none

module sfs_conv_model (
  // clock
  input wire logic core_clk,
  // switch drive pulses
  output logic sw_on_pulse,
  output logic sw_off_pulse,
  // sense comparators, low means no event
  output logic overcurrent_cmp,
  output logic open_loop_cmp,
  output logic overvoltage_cmp
);
  ////////////////////////////////////////////////////////////////////////////////
  // quiet converter at time zero
  initial begin
    sw_on_pulse = 1'b0;
    sw_off_pulse = 1'b0;
    overcurrent_cmp = 1'b0;
    open_loop_cmp = 1'b0;
    overvoltage_cmp = 1'b0;
  end
  // one switching period; hit picks {ov,ol,oc}, high on cycles a..b-1 after its arm
  // windows count from the arm edge so blanking edges can be straddled exactly
  task automatic cycle(input int ton, input int toff, input logic [2:0] hit,
                       input int a, input int b);
    int i;
    sw_on_pulse <= 1'b1;
    @(posedge core_clk);
    sw_on_pulse <= 1'b0;
    for (i = 1; i < ton; i++) begin
      overcurrent_cmp <= hit[0] && i >= a && i < b;
      open_loop_cmp <= hit[1] && i >= a && i < b;
      @(posedge core_clk);
    end
    overcurrent_cmp <= 1'b0;
    open_loop_cmp <= 1'b0;
    sw_off_pulse <= 1'b1;
    @(posedge core_clk);
    sw_off_pulse <= 1'b0;
    for (i = 1; i < toff; i++) begin
      overvoltage_cmp <= hit[2] && i >= a && i < b;
      @(posedge core_clk);
    end
    overvoltage_cmp <= 1'b0;
  endtask
endmodule

`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench for the second-stage fault supervisor
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // shortened restart ticks keep waits short
  localparam int FAST_TICK = 8;
  localparam int SLOW_TICK = 16;
  // clock, reset, apb master
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // converter side and outputs
  logic sw_on_pulse;
  logic sw_off_pulse;
  logic overcurrent_cmp;
  logic open_loop_cmp;
  logic overvoltage_cmp;
  logic internal_overtemp_fault = 1'b0;
  logic temp_sample_strobe;
  logic stage2_off;
  logic boost_off;
  // counters and switching phase lengths
  int bad_count = 0;
  int n_compared = 0;
  int ton = 120;
  int toff = 300;
  // register rows: address, reset value, written, read back, error
  typedef struct packed {
    logic [11:0] a;
    logic [7:0] rv;
    logic [7:0] wv;
    logic [7:0] ev;
    logic err;
  } sfs_row_t;
  sfs_row_t rows [7] = '{
    '{12'h13C, 8'h00, 8'hE0, 8'hE0, 1'b0}, '{12'h140, 8'h01, 8'h30, 8'h30, 1'b0},
    '{12'h144, 8'h22, 8'h4E, 8'h4E, 1'b0}, '{12'h148, 8'h20, 8'hE0, 8'hE0, 1'b0},
    '{12'h14C, 8'h04, 8'h08, 8'h08, 1'b0}, '{12'h150, 8'h01, 8'hFF, 8'h01, 1'b0},
    '{12'h200, 8'h00, 8'hFF, 8'h00, 1'b1}};
  // restart settings: two ticks fast, then two ticks slow
  logic [7:0] rs_val [2] = '{8'h08, 8'h0A};
  int rs_tick [2] = '{FAST_TICK, SLOW_TICK};
  ////////////////////////////////////////////////////////////////////////////////
  always #2 core_clk = ~core_clk;

  sfs_fault_supervisor #(.FAST_TICK_CYC(FAST_TICK), .SLOW_TICK_CYC(SLOW_TICK),
    .TEMP_FAST_CYC(4), .TEMP_SLOW_CYC(12)) sfs_fault_supervisor_i (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sw_on_pulse(sw_on_pulse), .sw_off_pulse(sw_off_pulse),
    .overcurrent_cmp(overcurrent_cmp), .open_loop_cmp(open_loop_cmp),
    .overvoltage_cmp(overvoltage_cmp), .internal_overtemp_fault(internal_overtemp_fault),
    .temp_sample_strobe(temp_sample_strobe), .stage2_off(stage2_off), .boost_off(boost_off));

  sfs_conv_model sfs_conv_model_i (.core_clk(core_clk), .sw_on_pulse(sw_on_pulse),
    .sw_off_pulse(sw_off_pulse), .overcurrent_cmp(overcurrent_cmp),
    .open_loop_cmp(open_loop_cmp), .overvoltage_cmp(overvoltage_cmp));
  ////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // one comparison, four-state exact
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // apb transfer: setup, access held until pready, then release and idle a cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      summarize();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, {24'h0, d}, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] ev, input logic ee);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk($sformatf("read %h", a), q, {24'h0, ev});
    chk($sformatf("pslverr %h", a), {31'h0, e}, {31'h0, ee});
  endtask
  // one switching period while counting shutdown cycles; lo..hi is the allowed span
  task automatic run(input logic [2:0] hit, input int a, input int b, input int lo,
                     input int hi, input logic sc);
    int n_off;
    int n_bst;
    n_off = 0;
    n_bst = 0;
    fork
      sfs_conv_model_i.cycle(ton, toff, hit, a, b);
      repeat (ton + toff) begin
        @(posedge core_clk);
        n_off += (stage2_off === 1'b1);
        n_bst += (boost_off === 1'b1);
      end
    join
    chk("stage2_off span", 32'(n_off >= lo && n_off <= hi), 32'h1);
    chk("boost_off span", 32'(sc ? (n_bst >= lo && n_bst <= hi) : (n_bst == 0)), 32'h1);
  endtask
  // strobe period after the rate has settled
  task automatic temp_period(input logic [7:0] rate, input logic ot, input int per);
    int n;
    int t;
    wr(12'h140, rate);
    internal_overtemp_fault <= ot;
    for (t = 0; t < 3; t++) begin
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
      end while (temp_sample_strobe !== 1'b1 && n < 40);
      if (n >= 40) begin
        bad_count++;
        summarize();
      end
    end
    chk("strobe period", 32'(n), 32'(per));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    // reset values, read-write, read-only status, unmapped slot
    for (int k = 0; k < 7; k++) begin
      rd(rows[k].a, rows[k].rv, rows[k].err);
      wr(rows[k].a, rows[k].wv);
      rd(rows[k].a, rows[k].ev, rows[k].err);
    end
    $display("test registers done");
    // overcurrent blank 75 cycles, count 2, unlatched, second stage only
    wr(12'h13C, 8'h00);
    run(3'h1, 76, 77, 0, 0, 1'b0);
    run(3'h1, 1, 76, 0, 0, 1'b0);
    for (int j = 0; j < 2; j++) begin
      wr(12'h14C, rs_val[j]);
      run(3'h1, 77, 120, 0, 0, 1'b0);
      run(3'h1, 77, 120, 0, 0, 1'b0);
      run(3'h0, 0, 0, 2 * rs_tick[j], 2 * rs_tick[j] + 2, 1'b0);
    end
    $display("test overcurrent done");
    // open loop blank 375 cycles, count 1, latched, both stages
    ton = 420;
    wr(12'h144, 8'hE3);
    wr(12'h140, 8'h02);
    wr(12'h14C, 8'h09);
    run(3'h2, 1, 376, 0, 0, 1'b0);
    run(3'h2, 376, 377, 0, 0, 1'b0);
    run(3'h0, 0, 0, 716, 720, 1'b1);
    rd(12'h150, 8'h14, 1'b0);
    run(3'h0, 0, 0, 720, 720, 1'b1);
    rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk("stage2_off after reset", {31'h0, stage2_off}, 32'h0);
    rd(12'h150, 8'h01, 1'b0);
    rd(12'h144, 8'h22, 1'b0);
    $display("test open loop done");
    // overvoltage: 200 cycles is blanked when fixed, seen after interval minus 125
    ton = 300;
    run(3'h4, 200, 251, 0, 0, 1'b0);
    run(3'h0, 0, 0, 0, 0, 1'b0);
    wr(12'h148, 8'h28);
    run(3'h4, 200, 251, 0, 0, 1'b0);
    run(3'h0, 0, 0, FAST_TICK, FAST_TICK + 2, 1'b0);
    $display("test overvoltage done");
    // forced overcurrent fault, first disabled then enabled
    wr(12'h13C, 8'h80);
    wr(12'h144, 8'h02);
    run(3'h0, 0, 0, 0, 0, 1'b0);
    wr(12'h13C, 8'h00);
    run(3'h0, 0, 0, 1, 600, 1'b0);
    // same forced fault made latched: at most one running sample, then held off
    wr(12'h144, 8'h12);
    run(3'h0, 0, 0, 590, 600, 1'b0);
    rd(12'h150, 8'h0C, 1'b0);
    wr(12'h144, 8'h22);
    $display("test forced fault done");
    // sensor sampling: fast, slow, fast while in overtemp fault
    temp_period(8'h00, 1'b0, 4);
    temp_period(8'h01, 1'b0, 12);
    temp_period(8'h01, 1'b1, 4);
    internal_overtemp_fault <= 1'b0;
    $display("test sampling done");
    summarize();
  end
endmodule

`default_nettype wire
